//--- core/pipelined_burst_sram_port.sv
// Purpose: synchronous port and core of a 256K x 18 pipelined burst SRAM
// Assumes: controller runs on I_CLK; drive, sleep and order are asynchronous
// Notes:   data bus split into input, output and enable; no forwarding of
//          a write to a read of the same word issued one edge later
`timescale 1ns/100ps
`include "sram_port_consts.svh"

module pipelined_burst_sram_port (
  // Clock and reset
  input  wire logic                      I_CLK,
  input  wire logic                      I_ARST_N,
  // Synchronous command inputs
  input  wire logic                      I_CLOCK_QUALIFIER_N,
  input  wire logic [`SRAM_ADDR_W-1:0]   I_ADDR,
  input  wire logic                      I_CHIP_SELECT_FIRST_N,
  input  wire logic                      I_CHIP_SELECT_SECOND,
  input  wire logic                      I_CHIP_SELECT_THIRD_N,
  input  wire logic                      I_ADVANCE_OR_LOAD,
  input  wire logic                      I_WRITE_STROBE_N,
  input  wire logic [`SRAM_LANES-1:0]    I_BYTE_LANE_WRITE_N,
  // Asynchronous controls and strap
  input  wire logic                      I_OUTPUT_DRIVE_N,
  input  wire logic                      I_SLEEP_REQUEST,
  input  wire logic                      I_BURST_ORDER,
  // Common data and parity bus, and sleep status
  input  wire sram_port_pkg::word_t      I_DATA,
  output sram_port_pkg::word_t           O_DATA,
  output logic                           O_DATA_OE,
  output logic                           O_SLEEPING
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  sram_port_pkg::word_t         mem [`SRAM_DEPTH];

  logic [`SRAM_SYNC_W-1:0]      sync1_q;
  logic [`SRAM_SYNC_W-1:0]      sync2_q;
  logic [`SRAM_SYNC_W-1:0]      sync3_q;
  logic [`SRAM_SYNC_W-1:0]      filt_q;
  localparam logic [`SRAM_SYNC_W-1:0] sync_rst = `SRAM_SYNC_RST;
  logic                         sleep_f;
  logic                         drive_n_f;
  logic                         order_f;

  sram_port_pkg::sleep_state_t  sleep_state_q;
  logic [1:0]                   sleep_cnt_q;
  logic                         awake;

  logic                         cmd_edge;
  logic                         select_all;
  logic                         load;
  logic                         advance;

  logic                         burst_active_q;
  logic                         burst_write_q;
  logic [`SRAM_ADDR_W-1:0]      burst_base_q;
  logic [`SRAM_BURST_W-1:0]     burst_beat_q;
  logic [`SRAM_BURST_W-1:0]     beat_next;

  sram_port_pkg::access_t       acc_d;
  sram_port_pkg::access_t       s1_q;
  sram_port_pkg::access_t       wr_q;
  sram_port_pkg::word_t         rd_data_q;
  logic                         drv_q;

  // ***************************************************************
  // Burst sequence
  // ***************************************************************
  function automatic logic [`SRAM_BURST_W-1:0] burst_low(
    input logic [`SRAM_BURST_W-1:0] start,
    input logic [`SRAM_BURST_W-1:0] beat,
    input logic                     interleave
  );
    if (interleave) begin
      burst_low = start ^ beat;
    end else begin
      burst_low = start + beat;
    end
  endfunction : burst_low

  // ***************************************************************
  // Asynchronous input filters
  // ***************************************************************
  // First stage is read by the second only; a change is accepted once
  // stages two and three agree, so one metastable sample cannot leak.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sync1_q <= `SRAM_SYNC_RST;
      sync2_q <= `SRAM_SYNC_RST;
      sync3_q <= `SRAM_SYNC_RST;
    end else begin
      sync1_q <= {I_BURST_ORDER, I_OUTPUT_DRIVE_N, I_SLEEP_REQUEST};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SRAM_SYNC_W; gi++) begin : g_filt
      always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
          filt_q[gi] <= sync_rst[gi];
        end else if (sync2_q[gi] == sync3_q[gi]) begin
          filt_q[gi] <= sync3_q[gi];
        end
      end
    end
  endgenerate

  assign sleep_f   = filt_q[`SRAM_SYNC_SLEEP];
  assign drive_n_f = filt_q[`SRAM_SYNC_DRIVE_N];
  assign order_f   = filt_q[`SRAM_SYNC_ORDER];

  // ***************************************************************
  // Sleep sequencer
  // ***************************************************************
  // Runs off the raw clock: sleep is not qualified by the clock qualifier.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sleep_state_q <= sram_port_pkg::SLP_RUN;
      sleep_cnt_q   <= 2'h0;
    end else begin
      case (sleep_state_q)
        sram_port_pkg::SLP_RUN: begin
          sleep_cnt_q <= 2'h0;
          if (sleep_f) begin
            sleep_state_q <= sram_port_pkg::SLP_ENTER;
          end
        end
        sram_port_pkg::SLP_ENTER: begin
          if (!sleep_f) begin
            sleep_state_q <= sram_port_pkg::SLP_WAKE;
            sleep_cnt_q   <= 2'h0;
          end else if (sleep_cnt_q == `SRAM_SLEEP_CYC - 2'h1) begin
            sleep_state_q <= sram_port_pkg::SLP_DOZE;
            sleep_cnt_q   <= 2'h0;
          end else begin
            sleep_cnt_q <= sleep_cnt_q + 2'h1;
          end
        end
        sram_port_pkg::SLP_DOZE: begin
          sleep_cnt_q <= 2'h0;
          if (!sleep_f) begin
            sleep_state_q <= sram_port_pkg::SLP_WAKE;
          end
        end
        sram_port_pkg::SLP_WAKE: begin
          if (sleep_cnt_q == `SRAM_SLEEP_CYC - 2'h1) begin
            sleep_state_q <= sram_port_pkg::SLP_RUN;
            sleep_cnt_q   <= 2'h0;
          end else begin
            sleep_cnt_q <= sleep_cnt_q + 2'h1;
          end
        end
        default: begin
          sleep_state_q <= sram_port_pkg::SLP_RUN;
          sleep_cnt_q   <= 2'h0;
        end
      endcase
    end
  end

  assign awake      = (sleep_state_q == sram_port_pkg::SLP_RUN);
  assign O_SLEEPING = (sleep_state_q == sram_port_pkg::SLP_DOZE);

  // ***************************************************************
  // Command decode
  // ***************************************************************
  assign cmd_edge   = !I_CLOCK_QUALIFIER_N && awake;
  assign select_all = !I_CHIP_SELECT_FIRST_N && I_CHIP_SELECT_SECOND &&
                      !I_CHIP_SELECT_THIRD_N;
  assign load       = cmd_edge && !I_ADVANCE_OR_LOAD;
  assign advance    = cmd_edge && I_ADVANCE_OR_LOAD;
  assign beat_next  = burst_beat_q + 2'h1;

  always_comb begin
    acc_d = '0;
    if (load) begin
      acc_d.valid = select_all;
      acc_d.write = !I_WRITE_STROBE_N;
      acc_d.addr  = I_ADDR;
    end else begin
      // Selects and strobe are don't-care while advancing
      acc_d.valid = burst_active_q;
      acc_d.write = burst_write_q;
      acc_d.addr  = {burst_base_q[`SRAM_ADDR_W-1:`SRAM_BURST_W],
                     burst_low(burst_base_q[`SRAM_BURST_W-1:0],
                               beat_next, order_f)};
    end
    acc_d.lanes = ~I_BYTE_LANE_WRITE_N;
  end

  // ***************************************************************
  // Burst counter
  // ***************************************************************
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      burst_active_q <= 1'b0;
      burst_write_q  <= 1'b0;
      burst_base_q   <= '0;
      burst_beat_q   <= 2'h0;
    end else if (!awake) begin
      burst_active_q <= 1'b0;
    end else if (load) begin
      burst_active_q <= select_all;
      burst_write_q  <= !I_WRITE_STROBE_N;
      burst_base_q   <= I_ADDR;
      burst_beat_q   <= 2'h0;
    end else if (advance) begin
      burst_beat_q   <= beat_next;
    end
  end

  // ***************************************************************
  // Access pipeline
  // ***************************************************************
  // Address stage; a new command is taken on every qualified edge in the run state.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      s1_q <= '0;
    end else if (!awake) begin
      s1_q.valid <= 1'b0;
    end else if (cmd_edge) begin
      s1_q <= acc_d;
    end
  end

  // Output stage: read data is registered, writes keep the bus floating.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      drv_q     <= 1'b0;
      rd_data_q <= '0;
    end else if (!awake) begin
      drv_q <= 1'b0;
    end else if (cmd_edge) begin
      drv_q <= s1_q.valid && !s1_q.write;
      if (s1_q.valid && !s1_q.write) begin
        rd_data_q <= mem[s1_q.addr];
      end
    end
  end

  // Write data stage: data is on the bus one edge after the float edge.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      wr_q <= '0;
    end else if (!awake) begin
      wr_q.valid <= 1'b0;
    end else if (cmd_edge) begin
      wr_q       <= s1_q;
      wr_q.valid <= s1_q.valid && s1_q.write;
    end
  end

  // Core array has no reset so that contents survive sleep and reset.
  always_ff @(posedge I_CLK) begin
    if (cmd_edge && wr_q.valid) begin
      for (int l = 0; l < `SRAM_LANES; l++) begin
        if (wr_q.lanes[l]) begin
          mem[wr_q.addr].data[l*`SRAM_LANE_W +: `SRAM_LANE_W] <=
            I_DATA.data[l*`SRAM_LANE_W +: `SRAM_LANE_W];
          mem[wr_q.addr].parity_lines[l] <= I_DATA.parity_lines[l];
        end
      end
    end
  end

  assign O_DATA    = rd_data_q;
  // Drive control only gates an already-registered read enable
  assign O_DATA_OE = drv_q && !drive_n_f && awake;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);

  property p_stall_holds;
    I_CLOCK_QUALIFIER_N && awake |=> $stable(s1_q) && $stable(wr_q) &&
      $stable(burst_beat_q) && $stable(drv_q);
  endproperty
  a_stall_holds: assert property (p_stall_holds)
    else $error("qualified-off edge changed state");

  property p_read_load;
    load && select_all && I_WRITE_STROBE_N |=> s1_q.valid &&
      !s1_q.write && s1_q.addr == $past(I_ADDR);
  endproperty
  a_read_load: assert property (p_read_load)
    else $error("read command not captured");

  property p_read_out;
    cmd_edge && s1_q.valid && !s1_q.write |=> drv_q &&
      O_DATA == $past(mem[s1_q.addr]);
  endproperty
  a_read_out: assert property (p_read_out)
    else $error("read data not registered one edge after capture");

  property p_write_float;
    // A read loaded on the float edge may drive once the data edge is past
    cmd_edge && s1_q.valid && s1_q.write |=> !O_DATA_OE ##1
      (!O_DATA_OE || $past(cmd_edge));
  endproperty
  a_write_float: assert property (p_write_float)
    else $error("bus driven during write sequence");

  property p_deselect;
    load && !select_all ##1 cmd_edge |=> !O_DATA_OE;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("deselect did not float the bus");

  property p_burst_upper;
    advance && burst_active_q |=> s1_q.valid &&
      s1_q.addr[`SRAM_ADDR_W-1:2] == $past(burst_base_q[`SRAM_ADDR_W-1:2]);
  endproperty
  a_burst_upper: assert property (p_burst_upper)
    else $error("burst changed upper address bits");

  property p_burst_type;
    advance && burst_active_q |=> s1_q.write == $past(burst_write_q);
  endproperty
  a_burst_type: assert property (p_burst_type)
    else $error("burst access type changed");

  property p_interleave;
    advance && burst_active_q && order_f |=> s1_q.addr[1:0] ==
      ($past(burst_base_q[1:0]) ^ $past(beat_next));
  endproperty
  a_interleave: assert property (p_interleave)
    else $error("interleaved beat address wrong");

  property p_linear;
    advance && burst_active_q && !order_f |=> s1_q.addr[1:0] ==
      2'($past(burst_base_q[1:0]) + $past(beat_next));
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear beat address wrong");

  property p_write_lane;
    cmd_edge && wr_q.valid && !wr_q.lanes[0] |=>
      mem[$past(wr_q.addr)].data[7:0] == $past(mem[wr_q.addr].data[7:0]);
  endproperty
  a_write_lane: assert property (p_write_lane)
    else $error("unselected lane was written");

  property p_sleep_entry;
    awake && sleep_f ##1 sleep_f [*2] |=> O_SLEEPING;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep not reached in two cycles");

endmodule : pipelined_burst_sram_port

//--- core/sram_port_consts.svh
// Purpose: constants of the pipelined burst SRAM port
// Assumes: included by the package and the port module
// Notes:   widths, reset values and sleep timing
//
// Overview of operation
// - Qualifier high at an edge while in run state: command, burst and pipeline state hold; the sleep sequencer and input filters still run.
// - Load edge, all selects active, write strobe high starts a read.
// - Read data leaves the output register one edge after address capture.
// - A new command is accepted right after a read, no wait state.
// - Deselect is pipelined: outputs float after the following edge.
// - The burst counter gives up to four beats from one address.
// - Burst order strap low is linear, high is interleaved.
// - Interleaved beat low bits equal start XOR beat index.
// - Only the two low address bits count and wrap; upper bits hold.
// - Advance high increments the counter, ignoring selects and strobe.
// - The write strobe is latched at burst start for the whole burst.
// - Load edge, all selects active, write strobe low starts a write.
// - Edge after a write command floats the bus, whatever output drive is.
// - Write data is taken two edges after the command.
// - Only lanes with active write selects change in the stored word.
// - Sleep input gives retention; entry and exit take two cycles.
// - Deselect before sleep; pending accesses may be lost.
// - Linear beat low bits count up modulo four from the start.
// - The port comes out of reset deselected with the bus floating.
// - Output drive is masked internally during write cycles.
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH

`define SRAM_ADDR_W       18
`define SRAM_DEPTH        262144
`define SRAM_LANES        2
`define SRAM_LANE_W       8
`define SRAM_BURST_W      2
`define SRAM_SYNC_W       3
// Reset values of the filtered asynchronous inputs: sleep, drive_n, order
`define SRAM_SYNC_RST     3'h2
`define SRAM_SYNC_SLEEP   0
`define SRAM_SYNC_DRIVE_N 1
`define SRAM_SYNC_ORDER   2
// Sleep entry and exit, in clock cycles
`define SRAM_SLEEP_CYC    2'h2

`endif

//--- core/sram_port_pkg.sv
// Purpose: types of the pipelined burst SRAM port
// Assumes: sram_port_consts.svh defines the widths
// Notes:   no constants live here, only types
`include "sram_port_consts.svh"

package sram_port_pkg;

  typedef struct packed {
    logic [`SRAM_LANES-1:0]               parity_lines;
    logic [`SRAM_LANES*`SRAM_LANE_W-1:0]  data;
  } word_t;

  typedef struct packed {
    logic                    valid;
    logic                    write;
    logic [`SRAM_LANES-1:0]  lanes;
    logic [`SRAM_ADDR_W-1:0] addr;
  } access_t;

  typedef enum logic [1:0] {
    SLP_RUN   = 2'b00,
    SLP_ENTER = 2'b01,
    SLP_DOZE  = 2'b10,
    SLP_WAKE  = 2'b11
  } sleep_state_t;

endpackage : sram_port_pkg

//--- tb/sram_bus_partner.sv
// Purpose: shared data bus between the port and its memory controller
// Assumes: the controller drives only during the data phase of a write
// Notes:   a released bus toggles each cycle, so stale data cannot match
`timescale 1ns/100ps
module sram_bus_partner (
  // Clock
  input  wire logic                 i_clk,
  // Controller and device drivers
  input  wire logic                 i_ctl_en,
  input  wire sram_port_pkg::word_t i_ctl_val,
  input  wire logic                 i_dev_oe,
  input  wire sram_port_pkg::word_t i_dev_val,
  // Resolved bus
  output sram_port_pkg::word_t      o_bus,
  output logic                      o_clash
);
  sram_port_pkg::word_t last_q;

  always_comb begin
    if (i_dev_oe)
      o_bus = i_dev_val;
    else if (i_ctl_en)
      o_bus = i_ctl_val;
    else
      o_bus = ~last_q;
  end

  // Both parties on the bus at once is reported to the bench
  assign o_clash = i_dev_oe & i_ctl_en;

  always_ff @(posedge i_clk) begin
    last_q <= o_bus;
  end
endmodule : sram_bus_partner

//--- tb/test_pipelined_burst_sram_port.sv
// Purpose: self-checking bench of the burst SRAM port
// Assumes: inputs change at the falling edge, outputs read 1 ns after rise
// Notes:   drive, sleep and order pass a filter, so idle cycles follow them
`timescale 1ns/100ps
module test_pipelined_burst_sram_port;
  logic                 clk, arst_n, qual_n, cs1_n, cs2, cs3_n, adv;
  logic                 we_n, drv_n, slp, order, bus_en, clash, oe, zz;
  logic [17:0]          addr;
  logic [1:0]           bw_n;
  sram_port_pkg::word_t bus_val, bus, dout;
  int                   mismatches, total_checks;

  pipelined_burst_sram_port DUT (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_CLOCK_QUALIFIER_N(qual_n),
    .I_ADDR(addr), .I_CHIP_SELECT_FIRST_N(cs1_n),
    .I_CHIP_SELECT_SECOND(cs2), .I_CHIP_SELECT_THIRD_N(cs3_n),
    .I_ADVANCE_OR_LOAD(adv), .I_WRITE_STROBE_N(we_n),
    .I_BYTE_LANE_WRITE_N(bw_n), .I_OUTPUT_DRIVE_N(drv_n),
    .I_SLEEP_REQUEST(slp), .I_BURST_ORDER(order), .I_DATA(bus),
    .O_DATA(dout), .O_DATA_OE(oe), .O_SLEEPING(zz));

  sram_bus_partner u_bus (
    .i_clk(clk), .i_ctl_en(bus_en), .i_ctl_val(bus_val),
    .i_dev_oe(oe), .i_dev_val(dout), .o_bus(bus), .o_clash(clash));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [17:0] pat(input logic [17:0] a);
    return {a[1:0] ^ 2'h1, a[15:0] ^ 16'h5a3c};
  endfunction : pat

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  // One qualified or stalled edge; s high means all three selects active
  task automatic step(input logic a_l, input logic w_n, input logic s,
    input logic [17:0] a = 18'h0, input logic [1:0] b = 2'h3,
    input logic de = 1'b0, input logic [17:0] d = 18'h0,
    input logic q = 1'b0);
    @(negedge clk);
    adv = a_l;
    we_n = w_n;
    cs1_n = ~s;
    cs2 = s;
    cs3_n = ~s;
    addr = a;
    bw_n = b;
    bus_en = de;
    bus_val = d;
    qual_n = q;
    @(posedge clk);
    #1;
    chk(clash, 1'b0);
  endtask : step

  task automatic idle(input int n);
    repeat (n) step(1'b0, 1'b1, 1'b0);
  endtask : idle

  task automatic wr1(input logic [17:0] a, input logic [1:0] b,
    input logic [17:0] d);
    step(1'b0, 1'b0, 1'b1, a, b);
    step(1'b0, 1'b1, 1'b0);
    chk(oe, 1'b0);
    step(1'b0, 1'b1, 1'b0, 18'h0, 2'h3, 1'b1, d);
    chk(oe, 1'b0);
  endtask : wr1

  task automatic rd1(input logic [17:0] a, input logic [17:0] e);
    step(1'b0, 1'b1, 1'b1, a);
    step(1'b0, 1'b1, 1'b0);
    chk(oe, 1'b1);
    chk(dout, e);
    step(1'b0, 1'b1, 1'b0);
    chk(oe, 1'b0);
  endtask : rd1

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_bytes();
    logic [17:0] e, n;
    e = pat(18'h00104);
    wr1(18'h00104, 2'h0, e);
    rd1(18'h00104, e);
    for (int b = 3; b >= 0; b--) begin
      n = pat(18'h03000 + b);
      wr1(18'h00104, b[1:0], n);
      if (!b[0]) e = {e[17], n[16], e[15:8], n[7:0]};
      if (!b[1]) e = {n[17], e[16], n[15:8], e[7:0]};
      rd1(18'h00104, e);
    end
  endtask : t_bytes

  task automatic t_lin_burst();
    step(1'b0, 1'b0, 1'b1, 18'h00206, 2'h0);
    step(1'b1, 1'b1, 1'b0, 18'h0, 2'h0);
    for (int k = 0; k < 4; k++) begin
      step(k < 2, 1'b1, 1'b0, 18'h0, 2'h0, 1'b1,
        pat({16'h0081, k[1:0] + 2'h2}));
      chk(oe, 1'b0);
    end
    step(1'b0, 1'b1, 1'b1, 18'h00204);
    for (int k = 0; k < 4; k++) begin
      step(1'b0, 1'b1, k < 3, {16'h0081, k[1:0] + 2'h1});
      chk(dout, pat({16'h0081, k[1:0]}));
    end
    step(1'b0, 1'b1, 1'b0);
    chk(oe, 1'b0);
  endtask : t_lin_burst

  task automatic t_int_burst();
    @(negedge clk);
    order = 1'b1;
    idle(6);
    step(1'b0, 1'b1, 1'b1, 18'h00205);
    for (int k = 0; k < 5; k++) begin
      step(1'b1, 1'b0, 1'b0);
      chk(oe, 1'b1);
      chk(dout, pat({16'h0081, 2'h1 ^ k[1:0]}));
      if (k == 1) begin
        step(1'b0, 1'b0, 1'b1, 18'h3ffff, 2'h0, 1'b0, 18'h0, 1'b1);
        step(1'b0, 1'b1, 1'b0, 18'h0, 2'h3, 1'b0, 18'h0, 1'b1);
        chk(dout, pat(18'h00204));
        chk(oe, 1'b1);
      end
    end
    idle(1);
    chk(oe, 1'b1);
    chk(dout, pat(18'h00204));
    idle(1);
    chk(oe, 1'b0);
    @(negedge clk);
    order = 1'b0;
    idle(6);
  endtask : t_int_burst

  task automatic t_drive_off();
    @(negedge clk);
    drv_n = 1'b1;
    idle(6);
    step(1'b0, 1'b1, 1'b1, 18'h00104);
    step(1'b0, 1'b1, 1'b0);
    chk(oe, 1'b0);
    @(negedge clk);
    drv_n = 1'b0;
    idle(6);
  endtask : t_drive_off

  task automatic t_sleep();
    @(negedge clk);
    slp = 1'b1;
    for (int i = 0; i < 12 && zz !== 1'b1; i++) idle(1);
    chk(zz, 1'b1);
    if (zz !== 1'b1) results();
    chk(oe, 1'b0);
    @(negedge clk);
    slp = 1'b0;
    for (int i = 0; i < 12 && zz !== 1'b0; i++) idle(1);
    chk(zz, 1'b0);
    if (zz !== 1'b0) results();
    idle(4);
    rd1(18'h00206, pat(18'h00206));
  endtask : t_sleep

  initial begin
    {arst_n, adv, we_n, bw_n, addr, slp, order, bus_en} = '0;
    {qual_n, cs1_n, cs2, cs3_n, drv_n} = 5'h0;
    bus_val = '0;
    mismatches = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    #1;
    chk(oe, 1'b0);
    @(negedge clk);
    arst_n = 1'b1;
    idle(6);
    chk(oe, 1'b0);
    t_bytes();
    t_lin_burst();
    t_int_burst();
    t_drive_off();
    t_sleep();
    results();
  end
endmodule : test_pipelined_burst_sram_port
